// *** thermal_alarm_status_mask.sv ***
// alarm flags, masks and conversion sequencing of a seven-channel monitor
// assumes an outside serial engine issuing single-cycle register reads and
// writes, and an analog front end giving a reading at each conversion end
`timescale 1ns/1ps
`default_nettype none

module thermal_alarm_status_mask #(
    parameter int CONV_CYCLES_P = thermal_alarm_pkg::CONV_CYCLES,
    parameter int EXTRA_CYCLES_P = thermal_alarm_pkg::RES_CANCEL_EXTRA_CYCLES
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // register port from the serial engine
    input wire thermal_alarm_pkg::reg_req_t i_req,
    output logic [7:0] o_rdata,
    // analog front end
    input wire logic [7:0] i_temp,
    input wire logic i_diode_open,
    output logic [2:0] o_channel,
    output logic o_conv_start,
    output logic o_res_cancel,
    // open-drain outputs, enable low while pulling low
    output logic o_alert_oe_n,
    output logic o_thermal_shutdown_output_n_oe_n
);
    // refused at elaboration: the counter needs at least a two-cycle conversion
    if (CONV_CYCLES_P < 2 || EXTRA_CYCLES_P < 1)
    begin : g_param_check
        $error("conversion counts too small");
    end

    localparam int CNT_W = $clog2(CONV_CYCLES_P + EXTRA_CYCLES_P + 1);

    logic [7:0] config1;
    logic [7:0] alert_mask;
    logic [7:0] shutdown_mask;
    logic [6:0] alert_status;
    logic [6:0] shutdown_status;
    logic [6:0] diode_fault;
    logic [6:0] alert_fault;
    logic [6:0] shutdown_fault;
    logic [7:0] alert_limit [thermal_alarm_pkg::CHANNELS];
    logic [7:0] shutdown_limit [thermal_alarm_pkg::CHANNELS];
    logic alert_line;
    logic shutdown_line;
    thermal_alarm_pkg::seq_state_t state;
    logic [2:0] chan;
    logic [CNT_W-1:0] count;
    logic conv_end;
    logic [6:0] set_alert;
    logic [6:0] set_shutdown;
    logic [6:0] fault_alert_next;
    logic [6:0] fault_shutdown_next;

    // status bit of a conversion channel: 0..5 remote 1..6, 6 local
    function automatic logic [6:0] onehot(input logic [2:0] c);
        onehot = 7'h01 << c;
    endfunction

    // limit index from register address, remote n sits at base+n, local at base+7
    function automatic logic [2:0] limit_index(input logic [7:0] a);
        limit_index = (a[3:0] == 4'h7) ? 3'(thermal_alarm_pkg::LOCAL_CH) : 3'(a[3:0] - 4'h1);
    endfunction

    function automatic logic is_limit(input logic [7:0] a, input logic [7:0] base);
        is_limit = (a[7:4] == base[7:4]) && (a[3:0] >= 4'h1) && (a[3:0] <= 4'h7);
    endfunction

    wire logic wr = i_req.write;
    wire logic [7:0] wa = i_req.addr;

    // configuration registers; reserved bits never store
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            config1 <= thermal_alarm_pkg::REG_RESET;
            alert_mask <= thermal_alarm_pkg::REG_RESET;
            shutdown_mask <= thermal_alarm_pkg::REG_RESET;
        end
        else if (wr)
        begin
            if (wa == thermal_alarm_pkg::ADDR_CONFIG1)
                config1 <= i_req.wdata & thermal_alarm_pkg::CFG1_WRITE_MASK;
            if (wa == thermal_alarm_pkg::ADDR_ALERT_MASK)
                alert_mask <= i_req.wdata & thermal_alarm_pkg::ALERT_MASK_WRITE_MASK;
            if (wa == thermal_alarm_pkg::ADDR_SHUTDOWN_MASK)
                shutdown_mask <= i_req.wdata & thermal_alarm_pkg::SHUTDOWN_MASK_WRITE_MASK;
        end
    end

    // threshold registers, one per channel
    generate
        for (genvar g = 0; g < thermal_alarm_pkg::CHANNELS; g++)
        begin : g_limit
            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                begin
                    alert_limit[g] <= thermal_alarm_pkg::ALERT_LIMIT_RESET[g];
                    shutdown_limit[g] <= thermal_alarm_pkg::SHUTDOWN_LIMIT_RESET[g];
                end
                else if (wr && limit_index(wa) == 3'(g))
                begin
                    if (is_limit(wa, thermal_alarm_pkg::ADDR_ALERT_LIMIT_BASE))
                        alert_limit[g] <= i_req.wdata;
                    if (is_limit(wa, thermal_alarm_pkg::ADDR_SHUTDOWN_LIMIT_BASE)
                        && thermal_alarm_pkg::SHUTDOWN_CAPABLE[g])
                        shutdown_limit[g] <= i_req.wdata;
                end
            end
        end
    endgenerate

    // conversion sequencer: long counts, so a simulation shortens them by parameter
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            state <= thermal_alarm_pkg::SEQ_PICK;
            chan <= 3'h0;
            count <= '0;
        end
        else
        begin
            case (state)
                thermal_alarm_pkg::SEQ_PICK:
                begin
                    count <= (chan == 3'h0 && config1[thermal_alarm_pkg::CFG1_RES_CANCEL_BIT])
                        ? CNT_W'(CONV_CYCLES_P + EXTRA_CYCLES_P - 1)
                        : CNT_W'(CONV_CYCLES_P - 1);
                    state <= thermal_alarm_pkg::SEQ_CONVERT;
                end
                thermal_alarm_pkg::SEQ_CONVERT:
                begin
                    // a faulted remote diode ends its visit after one probe cycle
                    if (conv_end)
                        state <= thermal_alarm_pkg::SEQ_DONE;
                    else
                        count <= count - CNT_W'(1);
                end
                thermal_alarm_pkg::SEQ_DONE:
                begin
                    // faulted channels are stepped past after a single probe cycle
                    chan <= (chan == 3'(thermal_alarm_pkg::LOCAL_CH)) ? 3'h0 : chan + 3'h1;
                    state <= thermal_alarm_pkg::SEQ_PICK;
                end
                default:
                    state <= thermal_alarm_pkg::SEQ_PICK;
            endcase
        end
    end

    // a faulted remote diode is still probed for one cycle, which frees it when reconnected
    wire logic skip = (chan != 3'(thermal_alarm_pkg::LOCAL_CH)) && diode_fault[chan];
    assign conv_end = (state == thermal_alarm_pkg::SEQ_CONVERT) && (count == '0 || skip);
    wire logic reading_ok = (chan == 3'(thermal_alarm_pkg::LOCAL_CH)) || !i_diode_open;

    // fault levels with hysteresis
    always_comb
    begin
        fault_alert_next = alert_fault;
        fault_shutdown_next = shutdown_fault;
        set_alert = 7'h00;
        set_shutdown = 7'h00;
        if (conv_end && reading_ok)
        begin
            if (i_temp > alert_limit[chan])
                fault_alert_next = alert_fault | onehot(chan);
            else if (i_temp < alert_limit[chan] - thermal_alarm_pkg::HYSTERESIS_C)
                fault_alert_next = alert_fault & ~onehot(chan);
            if (thermal_alarm_pkg::SHUTDOWN_CAPABLE[chan] && i_temp > shutdown_limit[chan])
                fault_shutdown_next = shutdown_fault | onehot(chan);
            else if (i_temp < shutdown_limit[chan] - thermal_alarm_pkg::HYSTERESIS_C)
                fault_shutdown_next = shutdown_fault & ~onehot(chan);
            set_alert = fault_alert_next & onehot(chan);
            set_shutdown = fault_shutdown_next & onehot(chan);
        end
    end

    wire logic rd_status1 = i_req.read && i_req.addr == thermal_alarm_pkg::ADDR_HIGH_LIMIT_STATUS;
    wire logic rd_status2 = i_req.read && i_req.addr == thermal_alarm_pkg::ADDR_SHUTDOWN_STATUS;

    // sticky flags: masks never gate them, a set in the clearing cycle wins
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            alert_fault <= 7'h00;
            shutdown_fault <= 7'h00;
            alert_status <= 7'h00;
            shutdown_status <= 7'h00;
        end
        else
        begin
            alert_fault <= fault_alert_next;
            shutdown_fault <= fault_shutdown_next;
            alert_status <= (rd_status1 ? 7'h00 : alert_status) | set_alert;
            shutdown_status <= (rd_status2 ? 7'h00 : shutdown_status) | set_shutdown;
        end
    end

    // diode fault, updated at each remote probe
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            diode_fault <= 7'h00;
        else if (conv_end && chan != 3'(thermal_alarm_pkg::LOCAL_CH))
            diode_fault[chan] <= i_diode_open;
    end

    // output lines: alert clears on status read, shutdown follows the fault level
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            alert_line <= 1'b0;
            shutdown_line <= 1'b0;
        end
        else
        begin
            alert_line <= (|(set_alert & ~alert_mask[6:0]))
                || (alert_line && !rd_status1);
            shutdown_line <= |(fault_shutdown_next & ~shutdown_mask[6:0]
                & thermal_alarm_pkg::SHUTDOWN_CAPABLE);
        end
    end

    // read data, registered; unmapped reads give zero
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_rdata <= 8'h00;
        else if (i_req.read)
        begin
            if (i_req.addr == thermal_alarm_pkg::ADDR_CONFIG1)
                o_rdata <= config1;
            else if (i_req.addr == thermal_alarm_pkg::ADDR_ALERT_MASK)
                o_rdata <= alert_mask;
            else if (i_req.addr == thermal_alarm_pkg::ADDR_SHUTDOWN_MASK)
                o_rdata <= shutdown_mask;
            else if (rd_status1)
                o_rdata <= {1'b0, alert_status};
            else if (rd_status2)
                o_rdata <= {1'b0, shutdown_status};
            else if (i_req.addr == thermal_alarm_pkg::ADDR_DIODE_FAULT)
                o_rdata <= {1'b0, diode_fault[5:0], 1'b0};
            else if (is_limit(i_req.addr, thermal_alarm_pkg::ADDR_ALERT_LIMIT_BASE))
                o_rdata <= alert_limit[limit_index(i_req.addr)];
            else if (is_limit(i_req.addr, thermal_alarm_pkg::ADDR_SHUTDOWN_LIMIT_BASE))
                o_rdata <= shutdown_limit[limit_index(i_req.addr)];
            else
                o_rdata <= 8'h00;
        end
    end

    assign o_channel = chan;
    assign o_conv_start = (state == thermal_alarm_pkg::SEQ_PICK);
    assign o_res_cancel = config1[thermal_alarm_pkg::CFG1_RES_CANCEL_BIT] && chan == 3'h0;
    assign o_alert_oe_n = ~alert_line;
    assign o_thermal_shutdown_output_n_oe_n = ~shutdown_line;
endmodule // thermal_alarm_status_mask

`default_nettype wire

// *** thermal_alarm_pkg.sv ***
// package for the thermal alarm status and mask block
// assumes one 10 MHz clock and a byte-wide register port
package thermal_alarm_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CHANNELS = 7;
    localparam int LOCAL_CH = 6;
    // register indices on the byte port
    localparam logic [7:0] ADDR_CONFIG1 = 8'h41;
    localparam logic [7:0] ADDR_ALERT_MASK = 8'h42;
    localparam logic [7:0] ADDR_SHUTDOWN_MASK = 8'h43;
    localparam logic [7:0] ADDR_HIGH_LIMIT_STATUS = 8'h44;
    localparam logic [7:0] ADDR_SHUTDOWN_STATUS = 8'h45;
    localparam logic [7:0] ADDR_DIODE_FAULT = 8'h46;
    localparam logic [7:0] ADDR_ALERT_LIMIT_BASE = 8'h10;
    localparam logic [7:0] ADDR_SHUTDOWN_LIMIT_BASE = 8'h20;
    // field positions
    localparam int CFG1_RES_CANCEL_BIT = 3;
    localparam logic [7:0] CFG1_WRITE_MASK = 8'hF8;
    localparam logic [7:0] ALERT_MASK_WRITE_MASK = 8'h7F;
    localparam logic [7:0] SHUTDOWN_MASK_WRITE_MASK = 8'h39;
    localparam logic [7:0] REG_RESET = 8'h00;
    // per-channel alert and shutdown limit resets, index = status bit
    localparam logic [7:0] ALERT_LIMIT_RESET [CHANNELS] = '{8'h6E, 8'h7F, 8'h64, 8'h64, 8'h64, 8'h64, 8'h5A};
    localparam logic [6:0] SHUTDOWN_CAPABLE = 7'h39;
    localparam logic [7:0] SHUTDOWN_LIMIT_RESET [CHANNELS] = '{8'h6E, 8'h7F, 8'h7F, 8'h7F, 8'h5A, 8'h5A, 8'h7F};
    localparam logic [7:0] HYSTERESIS_C = 8'h04;
    // timing
    localparam int CONV_TIME_MS = 125;
    localparam int RES_CANCEL_EXTRA_MS = 125;
    localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
    localparam int RES_CANCEL_EXTRA_CYCLES = CLK_HZ / 1000 * RES_CANCEL_EXTRA_MS;
    typedef enum logic [2:0]
    {
        SEQ_PICK = 3'b001,
        SEQ_CONVERT = 3'b010,
        SEQ_DONE = 3'b100
    } seq_state_t;
    typedef struct packed
    {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// *** thermal_alarm_checker.sv ***
// checker: timing and mask relations at the alarm block's ports
// assumes it is bound to the block and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_checker #(
    parameter int CONV_CYCLES_P = 8,
    parameter int EXTRA_CYCLES_P = 4
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // watched ports
    input wire thermal_alarm_pkg::reg_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0] o_channel,
    input wire logic o_conv_start,
    input wire logic o_res_cancel,
    input wire logic o_alert_oe_n,
    input wire logic o_thermal_shutdown_output_n_oe_n
);
    int cnt;
    int rcn;
    logic cfg_b3;
    logic [7:0] sdm;
    logic sdq;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // span between start pulses; count of cancel cycles tolerates a one-cycle channel lag
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cnt <= 0;
            rcn <= 0;
        end
        else if (o_conv_start)
        begin
            cnt <= 1;
            rcn <= int'(o_res_cancel);
        end
        else if (cnt != 0)
        begin
            cnt <= cnt + 1;
            rcn <= rcn + int'(o_res_cancel);
        end
    end
    // mirrors of written settings, stored bits only
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cfg_b3 <= 1'b0;
            sdm <= 8'h00;
        end
        else if (i_req.write)
        begin
            if (i_req.addr == thermal_alarm_pkg::ADDR_CONFIG1) cfg_b3 <= i_req.wdata[3];
            if (i_req.addr == thermal_alarm_pkg::ADDR_SHUTDOWN_MASK) sdm <= i_req.wdata & 8'h39;
        end
    end
    // all shutdown masks set, one cycle late
    always_ff @(posedge i_clk) sdq <= !i_reset && sdm == 8'h39;
    chk_res_cancel_ch: assert property (o_res_cancel == (cfg_b3 && o_channel == 3'h0))
        else $error("cancel level wrong");
    chk_conv_extra_len: assert property (o_conv_start && cnt != 0 && rcn > 2
        |-> cnt == CONV_CYCLES_P + EXTRA_CYCLES_P + 2) else $error("cancelled conversion length wrong");
    chk_conv_plain_len: assert property (o_conv_start && cnt != 0 && rcn <= 2
        |-> cnt == CONV_CYCLES_P + 2 || cnt == 3) else $error("conversion length wrong");
    chk_sdmask_readback: assert property (i_req.read && i_req.addr == 8'h43 |=> o_rdata == sdm)
        else $error("shutdown mask readback wrong");
    chk_sdmask_quiet: assert property (sdm == 8'h39 && sdq && $past(sdq)
        |-> o_thermal_shutdown_output_n_oe_n) else $error("masked shutdown pin driven");
    chk_alert_at_end: assert property ($fell(o_alert_oe_n) |-> ##1 o_conv_start)
        else $error("alert asserted away from conversion end");
    chk_alert_read_rel: assert property (i_req.read && i_req.addr == 8'h44 && !o_alert_oe_n
        |=> o_alert_oe_n or ##1 o_conv_start) else $error("alert not released by status read");
    chk_status_top_zero: assert property (i_req.read && i_req.addr == 8'h44 |=> !o_rdata[7])
        else $error("status top bit set");
    chk_unmapped_zero: assert property (i_req.read && i_req.addr == 8'h00 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (o_conv_start && rcn > 2);
    cover property (o_conv_start && cnt == 3);
    cover property ($fell(o_alert_oe_n));
endmodule // thermal_alarm_checker
bind thermal_alarm_status_mask thermal_alarm_checker #(.CONV_CYCLES_P(CONV_CYCLES_P),
    .EXTRA_CYCLES_P(EXTRA_CYCLES_P)) chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req),
    .o_rdata(o_rdata), .o_channel(o_channel), .o_conv_start(o_conv_start), .o_res_cancel(o_res_cancel),
    .o_alert_oe_n(o_alert_oe_n), .o_thermal_shutdown_output_n_oe_n(o_thermal_shutdown_output_n_oe_n));
`default_nettype wire

// *** thermal_fe_model.sv ***
// front-end stand-in: reading and diode-open flag per channel
// assumes the bench fills the tables by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none
module thermal_fe_model (
    // channel picked by the sequencer
    input wire logic [2:0] i_ch,
    // reading and open flag of that channel
    output logic [7:0] o_temp,
    output logic o_open
);
    logic [7:0] temps [7];
    logic opens [7];
    // code 7 is no channel: reading is the complement of channel 0's, open flag low
    assign o_temp = (i_ch < 3'h7) ? temps[i_ch] : ~temps[0];
    assign o_open = (i_ch < 3'h7) ? opens[i_ch] : 1'b0;
endmodule // thermal_fe_model
`default_nettype wire

// *** thermal_alarm_status_mask_tb_top.sv ***
// bench: register traffic, channel readings, pin and read-data checks
// assumes the package, model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_status_mask_tb_top;
    localparam int CONV = 8;
    localparam int EXTRA = 4;
    logic i_clk;
    logic i_reset;
    thermal_alarm_pkg::reg_req_t i_req;
    logic [7:0] o_rdata;
    logic [7:0] temp;
    logic dopen;
    logic [2:0] o_channel;
    logic o_conv_start;
    logic o_res_cancel;
    logic o_alert_oe_n;
    logic o_sd_oe_n;
    logic taken;
    logic [7:0] sd;
    logic [7:0] hys [3] = '{8'h70, 8'h6C, 8'h69};
    logic [15:0] exp_q [$];
    int n_fail;
    int checks;
    int gap;
    thermal_alarm_status_mask #(.CONV_CYCLES_P(CONV), .EXTRA_CYCLES_P(EXTRA)) dut_u (.i_clk(i_clk),
        .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata), .i_temp(temp), .i_diode_open(dopen),
        .o_channel(o_channel), .o_conv_start(o_conv_start), .o_res_cancel(o_res_cancel),
        .o_alert_oe_n(o_alert_oe_n), .o_thermal_shutdown_output_n_oe_n(o_sd_oe_n));
    thermal_fe_model fe_u (.i_ch(o_channel), .o_temp(temp), .o_open(dopen));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] got, input logic [7:0] care);
        checks++;
        if ((got & care) !== (e & care))
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask
    // each task drives just after an edge; idle() ends a burst
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] care);
        @(posedge i_clk);
        exp_q.push_back({care, e});
        i_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    endtask
    task automatic idle();
        @(posedge i_clk);
        i_req <= '0;
    endtask
    // waits out one whole visit of channel c, returns its length in cycles
    task automatic chan(input int c, output int n);
        int k;
        k = 0;
        n = 0;
        // sample on the falling edge, where the channel register has settled
        @(negedge i_clk);
        while (o_channel === 3'(c) && k < 400) begin @(negedge i_clk); k++; end
        while (o_channel !== 3'(c) && k < 400) begin @(negedge i_clk); k++; end
        while (o_channel === 3'(c) && k < 400) begin @(negedge i_clk); k++; n++; end
        if (k >= 400) cmp("channel wait", 8'h00, 8'h01, 8'hFF);
    endtask
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // read answers come one cycle after the read is taken
    always @(posedge i_clk) taken <= i_req.read;
    always @(negedge i_clk)
    begin
        if (taken === 1'b1)
        begin
            cmp("read data", exp_q[0][7:0], o_rdata, exp_q[0][15:8]);
            void'(exp_q.pop_front());
        end
    end
    initial
    begin
        repeat (30000) @(posedge i_clk);
        cmp("watchdog", 8'h00, 8'h01, 8'hFF);
        final_report();
    end
    initial
    begin
        i_reset = 1'b1;
        i_req = '0;
        n_fail = 0;
        checks = 0;
        for (int i = 0; i < 7; i++) fe_u.temps[i] = 8'h20;
        for (int i = 0; i < 7; i++) fe_u.opens[i] = i == 1;
        void'($urandom(32'h703CC39C));
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h43, 8'h00, 8'hFF);
        rd(8'h00, 8'h00, 8'hFF);
        wr(8'h43, 8'hFF);
        rd(8'h43, 8'h39, 8'hFF);
        wr(8'h42, 8'h02);
        idle();
        chan(3, gap);
        wr(8'h41, 8'h08);
        idle();
        chan(0, gap);
        cmp("cancel length", 8'(CONV + EXTRA + 2), 8'(gap), 8'hFF);
        chan(3, gap);
        wr(8'h41, 8'h00);
        idle();
        chan(0, gap);
        cmp("plain length", 8'(CONV + 2), 8'(gap), 8'hFF);
        chan(1, gap);
        cmp("skip length", 8'h03, 8'(gap), 8'hFF);
        rd(8'h46, 8'h04, 8'hFF);
        idle();
        // one hot channel at a time, masked then unmasked
        for (int c = 0; c < 7; c++)
        begin
            if (c == 1) continue;
            sd = 8'h39 & 8'(1 << c);
            for (int i = 0; i < 7; i++) fe_u.temps[i] <= 8'(i == c ? 8'h80 : 8'h20) | 8'($urandom % 16);
            rd(8'h44, 8'h00, 8'h80);
            wr(8'h42, 8'h02 | 8'(1 << c));
            wr(8'h43, sd);
            idle();
            chan(c, gap);
            chan(c, gap);
            cmp("alert pin", 8'h01, {7'h00, o_alert_oe_n}, 8'h01);
            cmp("shutdown pin", 8'h01, {7'h00, o_sd_oe_n}, 8'h01);
            rd(8'h44, 8'(1 << c), 8'hFF);
            rd(8'h45, sd, 8'(1 << c));
            wr(8'h42, 8'h02);
            wr(8'h43, 8'h00);
            idle();
            chan(c, gap);
            cmp("alert pin", 8'h00, {7'h00, o_alert_oe_n}, 8'h01);
            cmp("shutdown pin", 8'(sd == 8'h00), {7'h00, o_sd_oe_n}, 8'h01);
            rd(8'h44, 8'(1 << c), 8'hFF);
            idle();
            @(negedge i_clk);
            cmp("alert released", 8'h01, {7'h00, o_alert_oe_n}, 8'h01);
            chan(c, gap);
            cmp("alert again", 8'h00, {7'h00, o_alert_oe_n}, 8'h01);
        end
        fe_u.temps[6] <= 8'h20;
        // shutdown release needs the reading below limit less the margin
        for (int k = 0; k < 3; k++)
        begin
            fe_u.temps[0] <= hys[k];
            chan(0, gap);
            cmp("hysteresis pin", 8'(k == 2), {7'h00, o_sd_oe_n}, 8'h01);
        end
        final_report();
    end
endmodule // thermal_alarm_status_mask_tb_top
`default_nettype wire
